//--- imm_decoder_assertions.sv
/* port checker for the immediate operand decoder
   assumes it is bound onto the decoder top */
`timescale 1ns/100ps
module imm_decoder_assertions (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // word stream
    input wire [15:0] instr_i,
    input wire instr_valid_i,
    input wire sign_ext_i,
    // decoded outputs
    input wire [2:0] acc_op_o,
    input wire [31:0] acc_operand_o,
    input wire [1:0] aux_op_o,
    input wire [15:0] aux_operand_o,
    input wire [2:0] aux_reg_pointer_o,
    input wire [8:0] data_page_pointer_o,
    input wire mult_valid_o,
    input wire [15:0] mult_operand_o,
    input wire [7:0] repeat_counter_o,
    input wire indirect_o,
    input wire [6:0] aux_ctrl_o,
    input wire done_o
);
    reg second_q = 1'b0;
    reg [15:0] op_q = 16'h0000;
    wire op = instr_valid_i && !second_q;
    wire is_long = instr_i[15:12] == 4'hd && instr_i[7:0] < 8'h07
        && (instr_i[7:0] != 8'h00 || !instr_i[11]);
    wire [31:0] lx = sign_ext_i ? {{16{instr_i[15]}}, instr_i} : {16'h0000, instr_i};
    // tracks whether the next valid word is a long constant
    always @(posedge clk_i) begin
        if (!rst_n_i)
            second_q <= 1'b0;
        else if (instr_valid_i)
            second_q <= op && is_long;
        if (op)
            op_q <= instr_i;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_short_done: assert property (op && !is_long |=> done_o)
        else $error("short instruction without done");
    chk_long_wait: assert property (op && is_long |=> !done_o)
        else $error("long opcode completed without constant");
    chk_long_acc: assert property (second_q && instr_valid_i && op_q[7:0] != 8'h00
        |=> acc_op_o == $past(op_q[2:0])
        && acc_operand_o == $past((op_q[2] ? {16'h0000, instr_i} : lx) << op_q[11:8]))
        else $error("long accumulator operand wrong");
    chk_long_aux: assert property (second_q && instr_valid_i && op_q[7:0] == 8'h00
        |=> aux_op_o == 2'h1 && aux_operand_o == $past(instr_i))
        else $error("long aux load wrong");
    chk_add_acc_short_imm_zext: assert property (op && instr_i[15:8] == 8'hcc
        |=> acc_op_o == 3'h2 && acc_operand_o == {24'h0, $past(instr_i[7:0])})
        else $error("short add operand wrong");
    chk_arp_load: assert property (op && instr_i[15:8] == 8'h55 && instr_i[7:3] == 5'h18
        |=> aux_reg_pointer_o == $past(instr_i[2:0]))
        else $error("pointer load wrong");
    chk_page_load: assert property (op && instr_i[15:9] == 7'h64
        |=> data_page_pointer_o == $past(instr_i[8:0]))
        else $error("page pointer load wrong");
    chk_mult_sext: assert property (op && instr_i[15:13] == 3'h5 |=> mult_valid_o
        && mult_operand_o == {{3{$past(instr_i[12])}}, $past(instr_i[12:0])})
        else $error("multiply constant wrong");
    chk_repeat_count: assert property (op && instr_i[15:8] == 8'hcb
        |=> repeat_counter_o == $past(instr_i[7:0]))
        else $error("repeat count wrong");
    chk_indirect_field: assert property (op |=> indirect_o == $past(instr_i[7])
        && aux_ctrl_o == $past(instr_i[6:0]))
        else $error("indirect fields wrong");
    chk_repeat_step: assert property (op && !is_long && instr_i[15:8] != 8'hcb
        && repeat_counter_o != 8'h00 |=> repeat_counter_o == $past(repeat_counter_o) - 8'h01)
        else $error("repeat count not stepped");
    cover property (op && is_long);
    cover property (mult_valid_o);
    cover property (done_o && aux_op_o == 2'h1);
endmodule
bind immediate_operand_decoder imm_decoder_assertions chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .instr_i(instr_i), .instr_valid_i(instr_valid_i), .sign_ext_i(sign_ext_i),
    .acc_op_o(acc_op_o), .acc_operand_o(acc_operand_o), .aux_op_o(aux_op_o),
    .aux_operand_o(aux_operand_o), .aux_reg_pointer_o(aux_reg_pointer_o),
    .data_page_pointer_o(data_page_pointer_o), .mult_valid_o(mult_valid_o),
    .mult_operand_o(mult_operand_o), .repeat_counter_o(repeat_counter_o),
    .indirect_o(indirect_o), .aux_ctrl_o(aux_ctrl_o), .done_o(done_o));

//--- imm_decoder_consts.vh
/*
 constants for the immediate operand decoder: opcode patterns, field
 positions and widths. assumes 16-bit program words.
*/
`ifndef IMM_DECODER_CONSTS_VH
`define IMM_DECODER_CONSTS_VH

`define WORD_W 16
`define OP_HI_MSB 15
`define OP_HI_LSB 8
`define SHIFT_MSB 11
`define SHIFT_LSB 8
`define LONG_OP_MSB 15
`define LONG_OP_LSB 12
`define LONG_SEL_MSB 7
`define LONG_SEL_LSB 0
`define K8_MSB 7
`define K13_MSB 12
`define K9_MSB 8
`define K3_MSB 2
`define IND_BIT 7
`define ARSEL_MSB 10
`define ARSEL_LSB 8
`define STSHIFT_MSB 10
`define STSHIFT_LSB 8
`define PM_MSB 1
`define CM_MSB 1
`define BIT_MSB 11
`define BIT_LSB 8

`define OP_ADD_ACC_SHORT_IMM 8'hcc
`define OP_SUBK 8'hcd
`define OP_LOAD_ACC_SHORT_IMM 8'hca
`define OP_REPEAT_IMM 8'hcb
`define OP_ADD_AUX_SHORT_IMM 8'h7e
`define OP_SUB_AUX_SHORT_IMM 8'h7f
`define OP_LOAD_AUX_POINTER_IMM 8'h55
`define OP_LOAD_AUX_SHORT_IMM_HI 5'h18
`define OP_LOAD_PAGE_POINTER_IMM_HI 7'h64
`define OP_MULTIPLY_IMM_HI 3'h5
`define OP_LONG_HI 4'hd
`define OP_LOAD_AUX_LONG_IMM_HI 5'h1a
`define SEL_LOAD_ACC_LONG_IMM 8'h01
`define SEL_ADD_ACC_LONG_IMM 8'h02
`define SEL_SUB_ACC_LONG_IMM 8'h03
`define SEL_AND_ACC_LONG_IMM 8'h04
`define SEL_ORK 8'h05
`define SEL_XOR_ACC_LONG_IMM 8'h06
`define SEL_LOAD_AUX_LONG_IMM 8'h00

`define ACC_OP_NONE 3'h0
`define ACC_OP_LOAD 3'h1
`define ACC_OP_ADD 3'h2
`define ACC_OP_SUB 3'h3
`define ACC_OP_AND 3'h4
`define ACC_OP_OR 3'h5
`define ACC_OP_XOR 3'h6

`define AUX_OP_NONE 2'h0
`define AUX_OP_LOAD 2'h1
`define AUX_OP_ADD 2'h2
`define AUX_OP_SUB 2'h3

`define PC_RESET 16'h0000
`endif

//--- immediate_operand_decoder.v
/*
 immediate operand decoder: decodes short and long immediate opcodes
 from a sequential program word stream and drives the execution paths.
 assumes one program word per cycle when instr_valid_i is high, in order.
*/
`timescale 1ns/100ps
`include "imm_decoder_consts.vh"

module immediate_operand_decoder #(
    parameter WORD_W = 16,
    parameter ACC_W = 32
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // program word stream
    input wire [WORD_W-1:0] instr_i,
    input wire instr_valid_i,
    input wire sign_ext_i,
    // program counter and fetch control
    output wire [WORD_W-1:0] pc_o,
    output wire reissue_o,
    // accumulator path
    output reg [2:0] acc_op_o,
    output reg [ACC_W-1:0] acc_operand_o,
    // auxiliary register path
    output reg [1:0] aux_op_o,
    output reg [2:0] aux_sel_o,
    output reg [WORD_W-1:0] aux_operand_o,
    // pointers
    output reg [2:0] aux_reg_pointer_o,
    output reg [8:0] data_page_pointer_o,
    // multiplier path
    output reg mult_valid_o,
    output reg [WORD_W-1:0] mult_operand_o,
    // repeat
    output wire repeat_active_o,
    output wire [7:0] repeat_counter_o,
    // generic field decode of current word
    output reg indirect_o,
    output reg [6:0] aux_ctrl_o,
    output reg [2:0] store_shift_o,
    output reg [1:0] product_shift_code_o,
    output reg [1:0] compare_mode_field_o,
    output reg [3:0] bit_code_o,
    // completion
    output reg done_o
);

localparam ST_OPCODE = 2'b01;
localparam ST_SECOND = 2'b10;

reg [1:0] state_q;
reg [1:0] state_d;
reg [WORD_W-1:0] pc_q;
reg [WORD_W-1:0] op_q;
reg [WORD_W-1:0] held_q;
reg held_valid_q;

wire [7:0] hi = instr_i[`OP_HI_MSB:`OP_HI_LSB];
wire [7:0] lo = instr_i[`K8_MSB:0];
wire [3:0] shift_q = op_q[`SHIFT_MSB:`SHIFT_LSB];
wire is_long = (instr_i[`LONG_OP_MSB:`LONG_OP_LSB] == `OP_LONG_HI) &&
               (lo == `SEL_LOAD_ACC_LONG_IMM || lo == `SEL_ADD_ACC_LONG_IMM || lo == `SEL_SUB_ACC_LONG_IMM ||
                lo == `SEL_AND_ACC_LONG_IMM || lo == `SEL_ORK || lo == `SEL_XOR_ACC_LONG_IMM);
wire is_load_aux_long_imm = (instr_i[15:11] == `OP_LOAD_AUX_LONG_IMM_HI) && (lo == `SEL_LOAD_AUX_LONG_IMM);
wire is_repeat_imm = (hi == `OP_REPEAT_IMM);
wire rpt_load = instr_valid_i && (state_q == ST_OPCODE) && is_repeat_imm;
wire exec_stb;
wire rpt_active;

// long constant extension and shift
wire [ACC_W-1:0] k16_ext = sign_ext_i ?
    {{(ACC_W-WORD_W){instr_i[WORD_W-1]}}, instr_i} :
    {{(ACC_W-WORD_W){1'b0}}, instr_i};
wire [ACC_W-1:0] k16_shift = k16_ext << shift_q;
wire [ACC_W-1:0] k16_logic = {{(ACC_W-WORD_W){1'b0}}, instr_i} << shift_q;

repeat_counter #(
    .CNT_W(8)
) u_repeat (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .load_i(rpt_load),
    .count_i(instr_i[`K8_MSB:0]),
    .exec_i(exec_stb),
    .active_o(rpt_active),
    .count_o(repeat_counter_o)
);

// one issue of a short word other than the repeat opcode itself
assign exec_stb = instr_valid_i && (state_q == ST_OPCODE) && !is_repeat_imm &&
                  !(is_long || is_load_aux_long_imm);

// fsm: opcode word or waiting for second long word
always @* begin
    state_d = state_q;
    case (state_q)
        ST_OPCODE: begin
            if (instr_valid_i && (is_long || is_load_aux_long_imm)) begin
                state_d = ST_SECOND;
            end
        end
        ST_SECOND: begin
            if (instr_valid_i) begin
                state_d = ST_OPCODE;
            end
        end
        default: begin
            state_d = ST_OPCODE;
        end
    endcase
end

always @(posedge clk_i) begin
    if (!rst_n_i) begin
        state_q <= ST_OPCODE;
        pc_q <= `PC_RESET;
        op_q <= {WORD_W{1'b0}};
        held_q <= {WORD_W{1'b0}};
        held_valid_q <= 1'b0;
        acc_op_o <= `ACC_OP_NONE;
        acc_operand_o <= {ACC_W{1'b0}};
        aux_op_o <= `AUX_OP_NONE;
        aux_sel_o <= 3'h0;
        aux_operand_o <= {WORD_W{1'b0}};
        aux_reg_pointer_o <= 3'h0;
        data_page_pointer_o <= 9'h000;
        mult_valid_o <= 1'b0;
        mult_operand_o <= {WORD_W{1'b0}};
        indirect_o <= 1'b0;
        aux_ctrl_o <= 7'h00;
        store_shift_o <= 3'h0;
        product_shift_code_o <= 2'h0;
        compare_mode_field_o <= 2'h0;
        bit_code_o <= 4'h0;
        done_o <= 1'b0;
    end else begin
        state_q <= state_d;
        acc_op_o <= `ACC_OP_NONE;
        aux_op_o <= `AUX_OP_NONE;
        mult_valid_o <= 1'b0;
        done_o <= 1'b0;
        if (instr_valid_i && state_q == ST_OPCODE) begin
            op_q <= instr_i;
            held_q <= instr_i;
            held_valid_q <= !is_repeat_imm;
            // a repeated word is reissued, pc holds
            if (!(rpt_active && repeat_counter_o != 8'h00)) begin
                pc_q <= pc_q + 16'h0001;
            end
            // generic fields of the current word
            indirect_o <= instr_i[`IND_BIT];
            aux_ctrl_o <= instr_i[6:0];
            aux_sel_o <= instr_i[`ARSEL_MSB:`ARSEL_LSB];
            store_shift_o <= instr_i[`STSHIFT_MSB:`STSHIFT_LSB];
            product_shift_code_o <= instr_i[`PM_MSB:0];
            compare_mode_field_o <= instr_i[`CM_MSB:0];
            bit_code_o <= instr_i[`BIT_MSB:`BIT_LSB];
            if (!(is_long || is_load_aux_long_imm)) begin
                done_o <= 1'b1;
            end
            // short immediates, operand from the opcode word
            if (hi == `OP_ADD_ACC_SHORT_IMM) begin
                acc_op_o <= `ACC_OP_ADD;
                acc_operand_o <= {{(ACC_W-8){1'b0}}, lo};
            end else if (hi == `OP_SUBK) begin
                acc_op_o <= `ACC_OP_SUB;
                acc_operand_o <= {{(ACC_W-8){1'b0}}, lo};
            end else if (hi == `OP_LOAD_ACC_SHORT_IMM) begin
                acc_op_o <= `ACC_OP_LOAD;
                acc_operand_o <= {{(ACC_W-8){1'b0}}, lo};
            end else if (hi == `OP_ADD_AUX_SHORT_IMM) begin
                aux_op_o <= `AUX_OP_ADD;
                aux_sel_o <= aux_reg_pointer_o;
                aux_operand_o <= {8'h00, lo};
            end else if (hi == `OP_SUB_AUX_SHORT_IMM) begin
                aux_op_o <= `AUX_OP_SUB;
                aux_sel_o <= aux_reg_pointer_o;
                aux_operand_o <= {8'h00, lo};
            end else if (instr_i[15:11] == `OP_LOAD_AUX_SHORT_IMM_HI) begin
                aux_op_o <= `AUX_OP_LOAD;
                aux_operand_o <= {8'h00, lo};
            end else if (hi == `OP_LOAD_AUX_POINTER_IMM && lo[7:3] == 5'h18) begin
                aux_reg_pointer_o <= instr_i[`K3_MSB:0];
            end else if (instr_i[15:9] == `OP_LOAD_PAGE_POINTER_IMM_HI) begin
                data_page_pointer_o <= instr_i[`K9_MSB:0];
            end else if (instr_i[15:13] == `OP_MULTIPLY_IMM_HI) begin
                mult_valid_o <= 1'b1;
                mult_operand_o <= {{3{instr_i[`K13_MSB]}}, instr_i[`K13_MSB:0]};
            end
        end else if (instr_valid_i && state_q == ST_SECOND) begin
            pc_q <= pc_q + 16'h0001;
            done_o <= 1'b1;
            held_valid_q <= 1'b1;
            // long immediates, operand is the whole second word
            if (op_q[7:0] == `SEL_LOAD_AUX_LONG_IMM) begin
                aux_op_o <= `AUX_OP_LOAD;
                aux_operand_o <= instr_i;
            end else if (op_q[7:0] == `SEL_LOAD_ACC_LONG_IMM) begin
                acc_op_o <= `ACC_OP_LOAD;
                acc_operand_o <= k16_shift;
            end else if (op_q[7:0] == `SEL_ADD_ACC_LONG_IMM) begin
                acc_op_o <= `ACC_OP_ADD;
                acc_operand_o <= k16_shift;
            end else if (op_q[7:0] == `SEL_SUB_ACC_LONG_IMM) begin
                acc_op_o <= `ACC_OP_SUB;
                acc_operand_o <= k16_shift;
            end else if (op_q[7:0] == `SEL_AND_ACC_LONG_IMM) begin
                acc_op_o <= `ACC_OP_AND;
                acc_operand_o <= k16_logic;
            end else if (op_q[7:0] == `SEL_ORK) begin
                acc_op_o <= `ACC_OP_OR;
                acc_operand_o <= k16_logic;
            end else begin
                acc_op_o <= `ACC_OP_XOR;
                acc_operand_o <= k16_logic;
            end
        end
    end
end

assign pc_o = pc_q;
assign reissue_o = rpt_active && (repeat_counter_o != 8'h00);
assign repeat_active_o = rpt_active;

endmodule

//--- immediate_operand_decoder_tb.sv
/* self-checking bench for the immediate operand decoder
   assumes the program memory model and the bound checker */
`timescale 1ns/100ps
module immediate_operand_decoder_tb;
    reg clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg en = 1'b0;
    reg run = 1'b0;
    reg sign_ext_i = 1'b0;
    reg [31:0] seed = 32'h39cb7dbf;
    reg [15:0] n_words = 16'h0000;
    reg [105:0] q [$];
    integer err_total = 0;
    integer checks_done = 0;
    integer cycles = 0;
    integer pass;
    wire [15:0] instr_i, pc_o, aux_operand_o, mult_operand_o;
    wire [31:0] acc_operand_o;
    wire [8:0] data_page_pointer_o;
    wire [7:0] repeat_counter_o;
    wire [2:0] acc_op_o, aux_reg_pointer_o;
    wire [1:0] aux_op_o;
    wire instr_valid_i, mult_valid_o, done_o;
    always #10 clk_i = ~clk_i;
    prog_mem_model pmem (.en_i(en), .pc_i(pc_o), .end_i(n_words), .word_o(instr_i),
        .valid_o(instr_valid_i));
    immediate_operand_decoder dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .sign_ext_i(sign_ext_i), .pc_o(pc_o), .reissue_o(),
        .acc_op_o(acc_op_o), .acc_operand_o(acc_operand_o), .aux_op_o(aux_op_o),
        .aux_sel_o(), .aux_operand_o(aux_operand_o), .aux_reg_pointer_o(aux_reg_pointer_o),
        .data_page_pointer_o(data_page_pointer_o), .mult_valid_o(mult_valid_o),
        .mult_operand_o(mult_operand_o), .repeat_active_o(),
        .repeat_counter_o(repeat_counter_o), .indirect_o(), .aux_ctrl_o(), .store_shift_o(),
        .product_shift_code_o(), .compare_mode_field_o(), .bit_code_o(), .done_o(done_o));
    function [31:0] rnd(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            rnd = x ^ (x << 5);
        end
    endfunction
    task complete_run;
        begin
            if (err_total == 0 && checks_done > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    task cmp(input [8*8:1] what, input [105:0] e, input [105:0] g);
        begin
            checks_done = checks_done + 1;
            if (e !== g) begin
                err_total = err_total + 1;
                $display("wrong value %0s exp %h got %h", what, e, g);
            end
        end
    endtask
    // random program, expected record per issue (a repeated word gets one per reissue)
    task build;
        integer i;
        reg [15:0] pc, w, c, xv, mv;
        reg [31:0] av;
        reg [2:0] ao, aux_reg_pointer, sel;
        reg [1:0] xo;
        reg [8:0] dp;
        reg [7:0] rc;
        reg m, lg;
        begin
            pc = 0; aux_reg_pointer = 0; dp = 0; rc = 0;
            for (i = 0; i < 31; i = i + 1) begin
                seed = rnd(seed);
                c = seed[31:16]; sel = seed[6:4] % 3'd7;
                ao = 0; av = 0; xo = 0; xv = 0; m = 0; mv = 0; lg = 0;
                case (i == 29 ? 4'h8 : i == 30 ? 4'h0 : {1'b0, seed[2:0]})
                    0: begin w = {8'hcc, c[7:0]}; ao = 2; av = {24'h0, c[7:0]}; end
                    1: begin w = {8'hca, c[7:0]}; ao = 1; av = {24'h0, c[7:0]}; end
                    2: begin w = {8'h7e, c[7:0]}; xo = 2; xv = {8'h0, c[7:0]}; end
                    3: begin w = {8'h7f, c[7:0]}; xo = 3; xv = {8'h0, c[7:0]}; end
                    4: begin w = {8'h55, 5'h18, c[2:0]}; aux_reg_pointer = c[2:0]; end
                    5: begin w = {7'h64, c[8:0]}; dp = c[8:0]; end
                    6: begin w = {3'h5, c[12:0]}; m = 1; mv = {{3{c[12]}}, c[12:0]}; end
                    7: begin
                        lg = 1;
                        if (sel == 0) begin
                            w = {5'h1a, seed[10:8], 8'h00}; xo = 1; xv = c;
                        end else begin
                            w = {4'hd, seed[11:8], 5'h0, sel}; ao = sel;
                            av = (sign_ext_i && sel < 3'd4) ? {{16{c[15]}}, c} : {16'h0, c};
                            av = av << seed[11:8];
                        end
                    end
                    default: begin w = {8'hcb, 6'h0, c[1:0]}; rc = {6'h0, c[1:0]}; end
                endcase
                pmem.mem_q[pc] = w;
                if (lg)
                    pmem.mem_q[pc + 1] = c;
                // repeated word: pc held, count steps down per issue
                while (i == 30 && rc != 0) begin
                    rc = rc - 1;
                    q.push_back({pc, ao, av, xo, xv, m, mv, aux_reg_pointer, dp, rc});
                end
                pc = pc + 1 + lg;
                q.push_back({pc, ao, av, xo, xv, m, mv, aux_reg_pointer, dp, rc});
            end
            n_words <= pc;
        end
    endtask
    always @(posedge clk_i) begin
        if (run) begin
            seed = rnd(seed);
            en <= seed[0] | seed[1];
        end else
            en <= 1'b0;
    end
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles > 3000) begin
            err_total = err_total + 1;
            complete_run;
        end
        if (rst_n_i && done_o === 1'b1) begin
            if (q.size() == 0)
                cmp("done", 106'h0, 106'h1);
            else
                cmp("result", q.pop_front(), {pc_o, acc_op_o,
                    acc_op_o != 3'h0 ? acc_operand_o : 32'h0, aux_op_o,
                    aux_op_o != 2'h0 ? aux_operand_o : 16'h0, mult_valid_o,
                    mult_valid_o ? mult_operand_o : 16'h0, aux_reg_pointer_o,
                    data_page_pointer_o, repeat_counter_o});
        end
    end
    initial begin
        for (pass = 0; pass < 2; pass = pass + 1) begin
            @(posedge clk_i);
            rst_n_i <= 1'b0;
            sign_ext_i <= pass[0];
            @(posedge clk_i);
            build;
            repeat (15) @(posedge clk_i);
            rst_n_i <= 1'b1;
            run <= 1'b1;
            while (q.size() != 0) @(posedge clk_i);
            run <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
        complete_run;
    end
endmodule

//--- prog_mem_model.sv
/* program memory feeding sequential words to the decoder
   assumes pc_i is the decoder program counter */
`timescale 1ns/100ps
module prog_mem_model (
    // fetch side
    input wire en_i,
    input wire [15:0] pc_i,
    input wire [15:0] end_i,
    output wire [15:0] word_o,
    output wire valid_o
);
    reg [15:0] mem_q [0:255];
    // word at pc, scrambled outside a fetch
    assign valid_o = en_i && pc_i < end_i;
    assign word_o = valid_o ? mem_q[pc_i[7:0]] : ~mem_q[pc_i[7:0]];
endmodule

//--- repeat_counter.v
/*
 repeat counter: holds the remaining count of a repeat-immediate and
 flags that a repeat is in progress, up to and including its last issue.
 assumes the decoder pulses one execution strobe per issued short instruction other than the repeat opcode.
*/
`timescale 1ns/100ps
`include "imm_decoder_consts.vh"

module repeat_counter #(
    parameter CNT_W = 8
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // control
    input wire load_i,
    input wire [CNT_W-1:0] count_i,
    input wire exec_i,
    // status
    output wire active_o,
    output wire [CNT_W-1:0] count_o
);

reg [CNT_W-1:0] cnt_q;
reg act_q;

always @(posedge clk_i) begin
    if (!rst_n_i) begin
        cnt_q <= {CNT_W{1'b0}};
        act_q <= 1'b0;
    end else if (load_i) begin
        cnt_q <= count_i;
        act_q <= 1'b1;
    end else if (exec_i && act_q) begin
        if (cnt_q == {CNT_W{1'b0}}) begin
            act_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
end

assign active_o = act_q;
assign count_o = cnt_q;

endmodule
